// >>> rtl/bit_clock_gen.sv
// Bit clock generator: toggles its clock every half_div ticks of a source.
// Assumes src_tick is a one-cycle pulse on the CLK domain.
`timescale 1ns/100ps
module bit_clock_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Control
  input  wire logic             run,
  input  wire logic             src_tick,
  input  wire logic [DIV_W-1:0] half_div,
  // Clock and edge events
  output logic                  bclk,
  output logic                  will_rise,
  output logic                  will_fall,
  output logic                  rose,
  output logic                  fell
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic             next_bclk;
  logic             at_end;

  // A divider of zero behaves as one, so the clock never stalls while running.
  assign at_end = ({1'b0, cnt} + 1'b1) >= {1'b0, half_div};

  always_comb begin
    next_cnt  = cnt;
    next_bclk = bclk;
    will_rise = 1'b0;
    will_fall = 1'b0;
    if (!run) begin
      next_cnt  = '0;
      next_bclk = 1'b0;
    end else if (src_tick) begin
      if (at_end) begin
        next_cnt  = '0;
        next_bclk = ~bclk;
        will_rise = ~bclk;
        will_fall = bclk;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt  <= '0;
      bclk <= 1'b0;
      rose <= 1'b0;
      fell <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      bclk <= next_bclk;
      rose <= will_rise;
      fell <= will_fall;
    end
  end

endmodule

// >>> rtl/density_router.sv
// One data router: picks one of the stream lines for a single line position.
// Assumes the selector is held steady by a register.
`timescale 1ns/100ps
module density_router #(
  parameter int N = 4
) (
  // Candidate lines and choice
  input  wire logic [N-1:0]         lines,
  input  wire logic [$clog2(N)-1:0] sel,
  // Chosen line
  output logic                      pick
);

  assign pick = lines[sel];

endmodule

// >>> rtl/mp_audio_pkg.sv
// Shared constants and types of the multipurpose audio and general input port.
// Assumes a 32-bit APB register bus with byte addresses and word-aligned registers.
package mp_audio_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_DIV_IN  = 8'h04;
  localparam logic [7:0]  OFF_DIV_OUT = 8'h08;
  localparam logic [7:0]  OFF_ROUTE   = 8'h0C;
  localparam logic [7:0]  OFF_STATUS  = 8'h10;
  localparam logic [7:0]  OFF_GPI     = 8'h14;
  localparam logic [2:0]  WIN_TX      = 3'h1;
  localparam logic [2:0]  WIN_RX      = 3'h2;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_007F;
  localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
  localparam logic [15:0] RST_DIV     = 16'h0001;
  localparam logic [15:0] RST_ROUTE   = 16'hE4E4;
  localparam int          ST_RX_READY = 0;
  localparam int          ST_TX_TAKEN = 1;

  // ----------------------------------------------------------------
  // Stream geometry and pin positions
  // ----------------------------------------------------------------
  localparam int         LINES       = 4;
  localparam logic [5:0] LIMIT_PCM   = 6'h3F;
  localparam logic [5:0] LIMIT_PDM   = 6'h1F;
  localparam logic [5:0] CNT_IDLE    = 6'h3F;
  localparam int         PIN_BCK_IN  = 5;
  localparam int         PIN_BCK_OUT = 4;
  localparam int         SY_GENERAL_INPUT_ZERO     = 6;
  localparam int         SY_BUS      = 7;
  localparam int         SY_MCLK     = 8;
  localparam int         SY_FRAME    = 9;

  typedef enum logic [2:0] {
    MODE_GPI, MODE_PDM_IN, MODE_PDM_OUT, MODE_PDM_MIX, MODE_PCM_IN, MODE_PCM_OUT
  } mode_t;

  typedef struct packed {
    logic [24:0] unused;
    logic        out_run;
    logic        in_run;
    logic        mclk_src;
    logic        dual_edge;
    logic [2:0]  mode;
  } ctrl_t;

  typedef struct packed {
    logic [5:0] level;
    logic [5:0] enable;
  } pin_drive_t;

endpackage

// >>> rtl/multipurpose_audio_gpi_port.sv
// Multipurpose port: frame-sampled general inputs, or a master serial audio port.
// Assumes a 100 MHz CLK; all pin and clock-source inputs are asynchronous.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
module multipurpose_audio_gpi_port
  import mp_audio_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // APB register bus
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Clock sources
  input  wire logic        BUS_CLK_IN,
  input  wire logic        AUDIO_MCLK_IN,
  // Bus frame marker
  input  wire logic        FRAME_START,
  // General input zero and multipurpose pins
  input  wire logic        GENERAL_INPUT_ZERO,
  input  wire logic [5:0]  MP_PIN_IN,
  output logic      [5:0]  MP_PIN_OUT,
  output logic      [5:0]  MP_PIN_OE,
  // Captured frame state
  output logic      [6:0]  GPI_SAMPLE,
  output logic             GPI_STROBE
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic mode_t decode_mode(input logic [2:0] f);
    unique case (f)
      3'h0:    decode_mode = MODE_GPI;
      3'h1:    decode_mode = MODE_PDM_IN;
      3'h2:    decode_mode = MODE_PDM_OUT;
      3'h3:    decode_mode = MODE_PDM_MIX;
      3'h4:    decode_mode = MODE_PCM_IN;
      3'h5:    decode_mode = MODE_PCM_OUT;
      default: decode_mode = MODE_GPI;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) &&
                (a[7:5] == WIN_TX || a[7:5] == WIN_RX || a <= OFF_GPI);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [9:0] sync1;
  logic [9:0] sync2;
  logic [9:0] sync3;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {FRAME_START, AUDIO_MCLK_IN, BUS_CLK_IN, GENERAL_INPUT_ZERO, MP_PIN_IN};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ctrl_t       ctrl, next_ctrl;
  logic [15:0] div_in, next_div_in;
  logic [15:0] div_out, next_div_out;
  logic [15:0] route, next_route;
  logic [1:0]  flags, next_flags;
  logic [6:0]  gpi_cap, next_gpi_cap;
  logic [15:0] frame_cnt, next_frame_cnt;
  logic        gpi_strobe, next_gpi_strobe;
  logic [5:0]  cnt_in, next_cnt_in;
  logic [5:0]  cnt_out, next_cnt_out;
  logic [3:0]  tx_bit, next_tx_bit;
  logic [31:0] prdata, next_prdata;
  pin_drive_t  drive, next_drive;
  logic [31:0] tx_word [8];
  logic [31:0] next_tx_word [8];
  logic [31:0] rx_word [8];
  logic [31:0] next_rx_word [8];
  logic [31:0] rx_shift [8];
  logic [31:0] next_rx_shift [8];

  mode_t      mode;
  logic       pcm, dual, run_in, run_out, src_tick;
  logic       bclk_i, wrise_i, wfall_i, rose_i, fell_i;
  logic       bclk_o, wrise_o, wfall_o, rose_o, fell_o;
  logic [5:0] limit;
  logic [3:0] line_out, line_oclk, line_rose, line_fell, rx_pick, tx_pick;
  logic [5:0] line_cnt [4];
  logic       wr, set_ready, set_taken;
  logic [1:0] clr;

  // ----------------------------------------------------------------
  // Mode decode and clock generation
  // ----------------------------------------------------------------
  assign mode  = decode_mode(ctrl.mode);
  assign pcm   = (mode == MODE_PCM_IN) || (mode == MODE_PCM_OUT);
  assign dual  = ctrl.dual_edge && !pcm;
  assign limit = pcm ? LIMIT_PCM : LIMIT_PDM;
  // The sample format borrows the input-side generator for its bit clock.
  assign run_in  = ctrl.in_run && (mode != MODE_GPI) && (mode != MODE_PDM_OUT);
  assign run_out = ctrl.out_run && (mode == MODE_PDM_OUT || mode == MODE_PDM_MIX);
  assign src_tick = ctrl.mclk_src ? (sync2[SY_MCLK] && !sync3[SY_MCLK])
                                  : (sync2[SY_BUS] && !sync3[SY_BUS]);

  bit_clock_gen #(.DIV_W(16)) u_gen_in (
    .clk      (CLK),
    .srst     (SRST),
    .run      (run_in),
    .src_tick (src_tick),
    .half_div (div_in),
    .bclk     (bclk_i),
    .will_rise(wrise_i),
    .will_fall(wfall_i),
    .rose     (rose_i),
    .fell     (fell_i)
  );

  bit_clock_gen #(.DIV_W(16)) u_gen_out (
    .clk      (CLK),
    .srst     (SRST),
    .run      (run_out),
    .src_tick (src_tick),
    .half_div (div_out),
    .bclk     (bclk_o),
    .will_rise(wrise_o),
    .will_fall(wfall_o),
    .rose     (rose_o),
    .fell     (fell_o)
  );

  // ----------------------------------------------------------------
  // Per-line timing and routers
  // ----------------------------------------------------------------
  always_comb begin
    for (int l = 0; l < LINES; l++) begin
      line_out[l]  = (mode == MODE_PDM_OUT) || (mode == MODE_PCM_OUT) ||
                     (mode == MODE_PDM_MIX && l >= 2);
      line_oclk[l] = (mode == MODE_PDM_OUT) || (mode == MODE_PDM_MIX && l >= 2);
      line_rose[l] = line_oclk[l] ? rose_o : rose_i;
      line_fell[l] = line_oclk[l] ? fell_o : fell_i;
      line_cnt[l]  = line_oclk[l] ? cnt_out : cnt_in;
    end
  end

  for (genvar g = 0; g < LINES; g++) begin : g_route
    density_router #(.N(LINES)) u_rt_in (
      .lines(sync2[3:0]),
      .sel  (route[2*g+1:2*g]),
      .pick (rx_pick[g])
    );
    density_router #(.N(LINES)) u_rt_out (
      .lines(tx_bit),
      .sel  (route[2*g+9:2*g+8]),
      .pick (tx_pick[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign wr  = PSEL && PENABLE && PWRITE && is_mapped(PADDR);
  assign clr = (wr && PADDR == OFF_STATUS) ? PWDATA[1:0] : 2'h0;

  always_comb begin
    next_ctrl       = ctrl;
    next_div_in     = div_in;
    next_div_out    = div_out;
    next_route      = route;
    next_gpi_cap    = gpi_cap;
    next_frame_cnt  = frame_cnt;
    next_gpi_strobe = 1'b0;
    next_tx_bit     = tx_bit;
    next_tx_word    = tx_word;
    next_rx_word    = rx_word;
    next_rx_shift   = rx_shift;
    set_ready       = 1'b0;
    set_taken       = 1'b0;
    next_prdata     = prdata;

    // Bit counters advance with the clock fall, so the word clock moves with it.
    if (!run_in) begin
      next_cnt_in = CNT_IDLE;
    end else if (wfall_i) begin
      next_cnt_in = (cnt_in == limit) ? 6'h00 : cnt_in + 6'h01;
    end else begin
      next_cnt_in = cnt_in;
    end
    if (!run_out) begin
      next_cnt_out = CNT_IDLE;
    end else if (wfall_o) begin
      next_cnt_out = (cnt_out == limit) ? 6'h00 : cnt_out + 6'h01;
    end else begin
      next_cnt_out = cnt_out;
    end

    for (int l = 0; l < LINES; l++) begin
      if (mode == MODE_GPI) begin
        next_tx_bit[l] = 1'b0;
      end else if (line_out[l]) begin
        if (line_fell[l]) begin
          next_tx_bit[l] = tx_word[(pcm && line_cnt[l][5]) ? 2*l+1 : 2*l][~line_cnt[l][4:0]];
        end
        if (line_rose[l] && dual) begin
          next_tx_bit[l] = tx_word[2*l+1][~line_cnt[l][4:0]];
        end
        if (line_fell[l] && line_cnt[l] == 6'h00) begin
          set_taken = 1'b1;
        end
      end else begin
        if (line_rose[l]) begin
          if (pcm && line_cnt[l][5]) begin
            next_rx_shift[2*l+1] = {rx_shift[2*l+1][30:0], rx_pick[l]};
          end else begin
            next_rx_shift[2*l] = {rx_shift[2*l][30:0], rx_pick[l]};
          end
        end
        if (line_fell[l] && dual) begin
          next_rx_shift[2*l+1] = {rx_shift[2*l+1][30:0], rx_pick[l]};
        end
        if (line_fell[l] && line_cnt[l] == 6'h00) begin
          next_rx_word[2*l]   = next_rx_shift[2*l];
          next_rx_word[2*l+1] = next_rx_shift[2*l+1];
          set_ready           = 1'b1;
        end
      end
    end

    // A frame start stores the inputs together with the frame count.
    if (sync2[SY_FRAME] && !sync3[SY_FRAME]) begin
      next_gpi_cap    = {sync2[5:0], sync2[SY_GENERAL_INPUT_ZERO]};
      next_frame_cnt  = frame_cnt + 16'h0001;
      next_gpi_strobe = 1'b1;
    end

    // Hardware events win over a clear in the same cycle.
    next_flags = (flags & ~clr) | {set_taken, set_ready};

    if (wr) begin
      if (PADDR == OFF_CTRL) begin
        next_ctrl = ctrl_t'(PWDATA & CTRL_MASK);
      end
      if (PADDR == OFF_DIV_IN) begin
        next_div_in = PWDATA[15:0];
      end
      if (PADDR == OFF_DIV_OUT) begin
        next_div_out = PWDATA[15:0];
      end
      if (PADDR == OFF_ROUTE) begin
        next_route = PWDATA[15:0];
      end
      if (PADDR[7:5] == WIN_TX) begin
        next_tx_word[PADDR[4:2]] = PWDATA;
      end
    end

    if (PSEL && !PENABLE) begin
      if (PADDR[7:5] == WIN_TX) begin
        next_prdata = tx_word[PADDR[4:2]];
      end else if (PADDR[7:5] == WIN_RX) begin
        next_prdata = rx_word[PADDR[4:2]];
      end else begin
        case (PADDR)
          OFF_CTRL:    next_prdata = ctrl;
          OFF_DIV_IN:  next_prdata = {16'h0000, div_in};
          OFF_DIV_OUT: next_prdata = {16'h0000, div_out};
          OFF_ROUTE:   next_prdata = {16'h0000, route};
          OFF_STATUS:  next_prdata = {19'h0_0000, bclk_o, bclk_i, ctrl.mode, 6'h00, flags};
          OFF_GPI:     next_prdata = {frame_cnt, 9'h000, gpi_cap};
          default:     next_prdata = 32'h0000_0000;
        endcase
      end
    end

    // Pins stay inputs in general mode; both clock pins drive in every audio mode.
    next_drive.level[PIN_BCK_IN]  = bclk_i;
    next_drive.level[PIN_BCK_OUT] = pcm ? (run_in && (fell_i ? cnt_in[5] : drive.level[PIN_BCK_OUT]))
                                        : bclk_o;
    next_drive.level[3:0]         = tx_pick;
    next_drive.enable             = (mode == MODE_GPI) ? 6'h00 : {2'b11, line_out};
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl       <= ctrl_t'(RST_CTRL);
      div_in     <= RST_DIV;
      div_out    <= RST_DIV;
      route      <= RST_ROUTE;
      flags      <= 2'h0;
      gpi_cap    <= 7'h00;
      frame_cnt  <= 16'h0000;
      gpi_strobe <= 1'b0;
      cnt_in     <= CNT_IDLE;
      cnt_out    <= CNT_IDLE;
      tx_bit     <= 4'h0;
      prdata     <= 32'h0000_0000;
      drive      <= '0;
      for (int i = 0; i < 8; i++) begin
        tx_word[i]  <= 32'h0000_0000;
        rx_word[i]  <= 32'h0000_0000;
        rx_shift[i] <= 32'h0000_0000;
      end
    end else begin
      ctrl       <= next_ctrl;
      div_in     <= next_div_in;
      div_out    <= next_div_out;
      route      <= next_route;
      flags      <= next_flags;
      gpi_cap    <= next_gpi_cap;
      frame_cnt  <= next_frame_cnt;
      gpi_strobe <= next_gpi_strobe;
      cnt_in     <= next_cnt_in;
      cnt_out    <= next_cnt_out;
      tx_bit     <= next_tx_bit;
      prdata     <= next_prdata;
      drive      <= next_drive;
      tx_word    <= next_tx_word;
      rx_word    <= next_rx_word;
      rx_shift   <= next_rx_shift;
    end
  end

  assign PRDATA     = prdata;
  assign PREADY     = 1'b1;
  assign PSLVERR    = PSEL && PENABLE && !is_mapped(PADDR);
  assign MP_PIN_OUT = drive.level;
  assign MP_PIN_OE  = drive.enable;
  assign GPI_SAMPLE = gpi_cap;
  assign GPI_STROBE = gpi_strobe;

endmodule

// >>> tb/audio_peer_model.sv
// Behavioural sample-stream converter on the far side of the audio port.
// Assumes it receives bit and word clock from the port and never drives a clock itself.
`timescale 1ns/100ps
module audio_peer_model #(
  parameter logic [31:0] WORD_A = 32'hA5C3_0F96,
  parameter logic [31:0] WORD_B = 32'h3C5A_E187
) (
  // Clocks from the port
  input  wire logic       bclk,
  input  wire logic       wclk,
  // Data lines towards the port
  output logic      [3:0] data
);
  logic last_w;
  int   idx;

  initial begin
    data   = 4'h0;
    last_w = 1'b0;
    idx    = 31;
  end

  // Odd lines send the inverted word so that a line swap shows up.
  always @(negedge bclk) begin
    #1;
    idx    = (wclk !== last_w || idx == 0) ? 31 : idx - 1;
    last_w = wclk;
    for (int l = 0; l < 4; l++) begin
      data[l] = (wclk ? WORD_B[idx] : WORD_A[idx]) ^ l[0];
    end
  end
endmodule

// >>> tb/mp_port_properties.sv
// Concurrent checks on the ports of the multipurpose audio and general input port.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/100ps
module mp_port_properties
  import mp_audio_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // Register bus
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  // Frame marker and pins
  input wire logic        FRAME_START,
  input wire logic [5:0]  MP_PIN_OUT,
  input wire logic [5:0]  MP_PIN_OE,
  input wire logic [6:0]  GPI_SAMPLE,
  input wire logic        GPI_STROBE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  // The mode is shadowed from bus writes on the same edge as the design's register; the pins follow a cycle later.
  logic [2:0] mode_q;
  logic       in_run;
  logic       seen;
  logic [6:0] rises;
  logic [2:0] fell_p;
  logic       pcm_run;

  assign pcm_run = (mode_q == 3'h4 || mode_q == 3'h5) && in_run;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      mode_q <= 3'h0;
      in_run <= 1'b0;
      seen   <= 1'b0;
      rises  <= 7'h00;
      fell_p <= 3'h0;
    end else begin
      if (PSEL && PENABLE && PWRITE && PADDR == OFF_CTRL) begin
        mode_q <= PWDATA[2:0];
        in_run <= PWDATA[5];
      end
      fell_p <= {fell_p[1:0], $fell(MP_PIN_OUT[5])};
      seen   <= pcm_run && (seen || $rose(MP_PIN_OUT[4]));
      rises  <= $rose(MP_PIN_OUT[4]) ? 7'h00 : rises + 7'($rose(MP_PIN_OUT[5]));
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_clk_master: assert property ((mode_q != 3'h0 && mode_q < 3'h6) [*3] |-> MP_PIN_OE[5:4] == 2'b11)
    else $error("audio clock pins not driven");
  a_gpi_quiet: assert property (mode_q == 3'h0 [*3] |-> MP_PIN_OE == 6'h00)
    else $error("pin driven in general mode");
  a_mix_dirs: assert property (mode_q == 3'h3 [*3] |-> MP_PIN_OE == 6'h3C)
    else $error("mixed mode directions wrong");
  a_word_fall: assert property (pcm_run && $changed(MP_PIN_OUT[4]) |-> $fell(MP_PIN_OUT[5]))
    else $error("word clock moved off a bit clock fall");
  a_word_ratio: assert property (pcm_run && seen && $rose(MP_PIN_OUT[4]) |-> rises == 7'd64)
    else $error("bit clocks per word period not 64");
  a_tx_fall: assert property (mode_q == 3'h5 && seen && $changed(MP_PIN_OUT[0]) |-> fell_p != 3'h0)
    else $error("sample data changed away from a bit clock fall");
  a_frame_strobe: assert property ($rose(FRAME_START) |-> ##[1:6] GPI_STROBE)
    else $error("frame start not captured");
  a_strobe_pulse: assert property (GPI_STROBE |=> !GPI_STROBE)
    else $error("capture strobe longer than one cycle");
  a_sample_strobe: assert property ($changed(GPI_SAMPLE) |-> GPI_STROBE)
    else $error("capture changed without strobe");
endmodule

// >>> tb/multipurpose_audio_gpi_port_bench.sv
// Self-checking bench of the multipurpose audio and general input port.
// Assumes the package, the design, the peer model and the checker are compiled first.
`timescale 1ns/100ps
module multipurpose_audio_gpi_port_bench
  import mp_audio_pkg::*;
();
  localparam logic [31:0] PEER_A = 32'h5A0F_C396;
  localparam logic [31:0] PEER_B = 32'hE187_3C5A;

  logic        clk, srst, psel, penable, pwrite, bus_clk, mclk, frame, g0, use_model, e, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [31:0] tx [4];
  logic [63:0] cap0, cap3;
  logic [5:0]  gpi_drv, pin_in, pin_out, pin_oe;
  logic [3:0]  peer_data;
  logic [6:0]  gpi_sample;
  logic        gpi_strobe;
  int          error_cnt, compares, n;
  int          seed = 32'hcc25_fcb5;

  // A pin the port drives reads back its own level; released pins come from the far side.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (use_model ? {gpi_drv[5:4], peer_data} : gpi_drv));

  multipurpose_audio_gpi_port u_dut (
    .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUS_CLK_IN(bus_clk),
    .AUDIO_MCLK_IN(mclk), .FRAME_START(frame), .GENERAL_INPUT_ZERO(g0), .MP_PIN_IN(pin_in),
    .MP_PIN_OUT(pin_out), .MP_PIN_OE(pin_oe), .GPI_SAMPLE(gpi_sample), .GPI_STROBE(gpi_strobe)
  );

  audio_peer_model #(.WORD_A(PEER_A), .WORD_B(PEER_B)) u_peer (
    .bclk(pin_out[5]),
    .wclk(pin_out[4]),
    .data(peer_data)
  );

  initial begin clk = 1'b0; forever #5 clk = ~clk; end
  initial begin bus_clk = 1'b0; #3; forever #40 bus_clk = ~bus_clk; end
  initial begin mclk = 1'b0; #7; forever #48 mclk = ~mclk; end

  // ----------------------------------------------------------------
  // Bus, comparison and expectation helpers
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w >= 50) error_cnt++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [5:0] oe_exp(input logic [2:0] m);
    case (m)
      3'h1, 3'h4: return 6'h30;
      3'h2, 3'h5: return 6'h3F;
      3'h3:       return 6'h3C;
      default:    return 6'h00;
    endcase
  endfunction

  function automatic logic [31:0] word_exp(input logic ch, input logic odd);
    return (ch ? PEER_B : PEER_A) ^ {32{odd}};
  endfunction

  task automatic summarize();
    $display("errors %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #500_000;
    error_cnt++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, frame, g0, use_model} = 6'h00;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    gpi_drv = 6'h00;
    srst    = 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(q, RST_CTRL);
    apb(1'b0, OFF_DIV_OUT, 32'h0);
    chk(q, {16'h0000, RST_DIV});
    apb(1'b0, OFF_ROUTE, 32'h0);
    chk(q, {16'h0000, RST_ROUTE});
    apb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    chk(32'(pin_oe), 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      gpi_drv <= 6'($random(seed));
      g0      <= 1'($random(seed));
      repeat (5) @(posedge clk);
      frame <= 1'b1;
      n = 0;
      while (gpi_strobe !== 1'b1 && n < 20) begin
        @(posedge clk);
        n++;
      end
      chk(32'(gpi_sample), 32'({gpi_drv, g0}));
      frame <= 1'b0;
      apb(1'b0, OFF_GPI, 32'h0);
      chk(32'(q[6:0]), 32'({gpi_drv, g0}));
    end
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, OFF_CTRL, 32'(m));
      repeat (4) @(posedge clk);
      chk(32'(pin_oe), 32'(oe_exp(3'(m))));
    end
    for (int k = 0; k < 4; k++) begin
      tx[k] = $random(seed);
      apb(1'b1, 8'(k < 2 ? 32 + 4 * k : 48 + 4 * k), tx[k]);
    end
    apb(1'b1, OFF_CTRL, 32'h0000_0025);
    @(posedge pin_out[4]);
    @(negedge pin_out[4]);
    for (int b = 63; b >= 0; b--) begin
      @(posedge pin_out[5]);
      cap0[b] = pin_out[0];
      cap3[b] = pin_out[3];
    end
    chk(cap0[63:32], tx[0]);
    chk(cap0[31:0], tx[1]);
    chk(cap3[63:32], tx[2]);
    chk(cap3[31:0], tx[3]);
    apb(1'b1, OFF_CTRL, 32'h0);
    // Dual-edge density output: the first output clock fall opens a 32-bit cycle.
    apb(1'b1, OFF_CTRL, 32'h0000_004A);
    @(negedge pin_out[4]);
    for (int b = 31; b >= 0; b--) begin
      @(posedge pin_out[4]);
      cap0[b] = pin_out[0];
      @(negedge pin_out[4]);
      cap0[b+32] = pin_out[0];
    end
    chk(cap0[31:0], tx[0]);
    chk(cap0[63:32], tx[1]);
    apb(1'b1, OFF_CTRL, 32'h0);
    use_model <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h0000_0034);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFF_STATUS, 32'h1);
      n = 0;
      do begin
        apb(1'b0, OFF_STATUS, 32'h0);
        n++;
      end while (q[ST_RX_READY] !== 1'b1 && n < 1000);
      chk(32'(q[ST_RX_READY]), 32'h0000_0001);
      chk(32'(q[10:8]), 32'h0000_0004);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(q, word_exp(1'b0, 1'b0));
    apb(1'b0, 8'h44, 32'h0);
    chk(q, word_exp(1'b1, 1'b0));
    apb(1'b0, 8'h48, 32'h0);
    chk(q, word_exp(1'b0, 1'b1));
    apb(1'b1, OFF_CTRL, 32'h0);
    summarize();
  end
endmodule

bind multipurpose_audio_gpi_port mp_port_properties u_props (
  .CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .FRAME_START, .MP_PIN_OUT, .MP_PIN_OE, .GPI_SAMPLE, .GPI_STROBE
);
